//--- src/bcr_pkg.sv
// Constants and types shared by the configuration register set
`default_nettype none
package bcr_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned TIMEOUT_UNIT_MS = 128;  // Timeout byte unit
  localparam int unsigned PROBE_WAIT_MS   = 50;   // Wait before probe

  // Configuration byte offsets
  localparam logic [3:0] OFS_SIG_LO      = 4'h0;
  localparam logic [3:0] OFS_SIG_HI      = 4'h1;
  localparam logic [3:0] OFS_EVENT_CMD   = 4'h2;
  localparam logic [3:0] OFS_POWER_MGMT  = 4'h3;
  localparam logic [3:0] OFS_INIT_TMO    = 4'h4;
  localparam logic [3:0] OFS_LINK_DRIVE  = 4'h5;
  localparam logic [3:0] OFS_DESIG_LO    = 4'h6;
  localparam logic [3:0] OFS_DESIG_HI    = 4'h7;

  // Field positions in link_and_drive_control
  localparam int unsigned BIT_LINK_HS     = 7;
  localparam int unsigned BIT_CB_LEN_16   = 6;
  localparam int unsigned BIT_DRIVE_SEL   = 5;
  localparam int unsigned BIT_ATAPI_RST   = 4;
  localparam int unsigned BIT_DEV_KIND    = 3;
  localparam int unsigned BIT_FS_LOCK     = 2;
  localparam int unsigned BIT_MSC_RST     = 1;
  localparam int unsigned BIT_RDY_POL     = 0;

  // Writable bits of link_and_drive_control
  localparam logic [7:0] LINK_DRIVE_WMASK = 8'h77;

  // Internal ROM defaults, also the values after reset
  localparam logic [7:0] RST_EVENT_CMD   = 8'h00;
  localparam logic [7:0] RST_POWER_MGMT  = 8'h00;
  localparam logic [7:0] RST_INIT_TMO    = 8'h80;
  localparam logic [7:0] RST_LINK_DRIVE  = 8'h00;
  localparam logic [7:0] RST_DESIG_LO    = 8'h24;
  localparam logic [7:0] RST_DESIG_HI    = 8'h24;

  // Width of the drive initialisation millisecond counter
  localparam int unsigned MS_W = 15;

  // Drive initialisation states, Gray from IDLE to DONE along the APM path
  typedef enum logic [2:0] {
    BCR_IDLE  = 3'h0,
    BCR_RESET = 3'h1,
    BCR_POLL  = 3'h3,
    BCR_APM   = 3'h2,
    BCR_DONE  = 3'h6,
    BCR_CTL   = 3'h4
  } bcr_init_e;

  // Configuration bytes held in hardware
  typedef struct packed {
    logic [7:0] event_notify_command;
    logic [7:0] power_mgmt_level;
    logic [7:0] drive_init_timeout;
    logic [7:0] link_and_drive_control;
    logic [7:0] vendor_cmd_designator_low;
    logic [7:0] vendor_cmd_designator_high;
  } bcr_cfg_s;

  // Whole state of the top module
  typedef struct packed {
    bcr_cfg_s        cfg;
    logic            rdy_s1;
    logic            rdy_s2;
    logic            mode_s1;
    logic            mode_s2;
    logic            drive_ready;
    logic [7:0]      rd_data;
    logic            mem_wr;
    logic [3:0]      mem_addr;
    logic [7:0]      mem_data;
    logic [5:0]      probe_ms;
    logic            probe_done;
    logic            probe_pulse;
    bcr_init_e       init;
    logic [MS_W-1:0] init_ms;
    logic            drive_reset;
    logic            devctl_wr;
    logic            set_features;
    logic            init_active;
  } bcr_state_s;

endpackage
`default_nettype wire

//--- src/bcr_ms_tick.sv
// Millisecond tick generator for the configuration register set
`default_nettype none
module bcr_ms_tick #(
  parameter int unsigned P_CYC_PER_MS = 25000
) (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  // Tick out
  output logic      o_tick
);

  localparam int unsigned CW = $clog2(P_CYC_PER_MS + 1);
  localparam logic [CW-1:0] LAST = CW'(P_CYC_PER_MS - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_q;

  // Count cycles of one millisecond
  always_comb begin
    cnt_d = (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
  end

  // Register counter and tick
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= (cnt_q == LAST);
    end
  end

  assign o_tick = tick_q;

endmodule
`default_nettype wire

//--- src/bcr_config_regs.sv
// Configuration register set: loading, vendor writes and drive setup
`default_nettype none
module bcr_config_regs
  import bcr_pkg::*;
#(
  parameter int unsigned P_CYC_PER_MS = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  // Configuration image load (ROM, serial memory or identify data)
  input  wire logic        i_load_valid,
  input  wire logic [3:0]  i_load_addr,
  input  wire logic [7:0]  i_load_data,
  // Host vendor write to serial memory configuration space
  input  wire logic        i_vwr_valid,
  input  wire logic [3:0]  i_vwr_addr,
  input  wire logic [7:0]  i_vwr_data,
  // Write passed on to the serial memory
  output logic             o_mem_wr,
  output logic [3:0]       o_mem_addr,
  output logic [7:0]       o_mem_data,
  // Register read port
  input  wire logic [3:0]  i_rd_addr,
  output logic [7:0]       o_rd_data,
  // Status from the link and the drive side
  input  wire logic        i_link_high_speed,
  input  wire logic        i_device_kind_flag,
  input  wire logic        i_apm_supported,
  input  wire logic        i_skip_init,
  // Pins
  input  wire logic        i_drive_ready_in,
  input  wire logic        i_identify_mode,
  // Drive initialisation control
  input  wire logic        i_init_start,
  input  wire logic        i_reset_complete,
  output logic             o_init_active,
  output logic             o_drive_reset,
  output logic             o_devctl_wr,
  output logic             o_set_features,
  output logic [7:0]       o_power_mgmt_level,
  output logic             o_atapi_reset_en,
  output logic             o_drive_select,
  // Serial memory probe request
  output logic             o_probe_serial,
  // Link and command decode controls
  output logic             o_full_speed_lock,
  output logic             o_cb_len_16,
  output logic             o_msc_soft_reset_sel,
  output logic [7:0]       o_event_notify_cmd,
  output logic             o_event_notify_en,
  output logic             o_drive_ready,
  input  wire logic [15:0] i_cb_designator,
  output logic             o_vendor_ata_match
);

  bcr_state_s s_q;
  bcr_state_s s_d;
  logic       tick;

  // Cycle to millisecond prescaler
  bcr_ms_tick #(
    .P_CYC_PER_MS (P_CYC_PER_MS)
  ) u_tick (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .o_tick     (tick)
  );

  // Store one configuration byte; signature and upper bytes are dropped
  function automatic bcr_cfg_s apply_byte(
    input bcr_cfg_s   c,
    input logic [3:0] addr,
    input logic [7:0] data
  );
    bcr_cfg_s r;
    r = c;
    case (addr)
      OFS_EVENT_CMD:  r.event_notify_command = data;
      OFS_POWER_MGMT: r.power_mgmt_level = data;
      OFS_INIT_TMO:   r.drive_init_timeout = data;
      OFS_LINK_DRIVE: begin
        r.link_and_drive_control = data & LINK_DRIVE_WMASK;
      end
      OFS_DESIG_LO:   r.vendor_cmd_designator_low = data;
      OFS_DESIG_HI:   r.vendor_cmd_designator_high = data;
      default:        r = c;
    endcase
    return r;
  endfunction

  // Timeout limit in milliseconds
  function automatic logic [MS_W-1:0] timeout_ms(input logic [7:0] v);
    return MS_W'(v) * MS_W'(TIMEOUT_UNIT_MS);
  endfunction

  // Next-state logic
  always_comb begin
    logic [MS_W-1:0] limit;
    logic            expired;
    logic            want_apm;
    s_d      = s_q;
    limit    = timeout_ms(s_q.cfg.drive_init_timeout);
    expired  = 1'b0;
    want_apm = 1'b0;

    // Pin synchronisers
    s_d.rdy_s1  = i_drive_ready_in;
    s_d.rdy_s2  = s_q.rdy_s1;
    s_d.mode_s1 = i_identify_mode;
    s_d.mode_s2 = s_q.mode_s1;

    // Ready polarity, forced active high in identify mode
    if (s_q.mode_s2) begin
      s_d.drive_ready = s_q.rdy_s2;
    end else begin
      s_d.drive_ready = s_q.rdy_s2 ^ s_q.cfg.link_and_drive_control[BIT_RDY_POL];
    end

    // Image loads; vendor write wins on the same cycle
    s_d.mem_wr = 1'b0;
    if (i_vwr_valid) begin
      s_d.cfg      = apply_byte(s_q.cfg, i_vwr_addr, i_vwr_data);
      s_d.mem_wr   = 1'b1;
      s_d.mem_addr = i_vwr_addr;
      s_d.mem_data = i_vwr_data;
    end else if (i_load_valid) begin
      s_d.cfg = apply_byte(s_q.cfg, i_load_addr, i_load_data);
    end

    // Register read, live status bits merged into 0x5
    case (i_rd_addr)
      OFS_EVENT_CMD:  s_d.rd_data = s_q.cfg.event_notify_command;
      OFS_POWER_MGMT: s_d.rd_data = s_q.cfg.power_mgmt_level;
      OFS_INIT_TMO:   s_d.rd_data = s_q.cfg.drive_init_timeout;
      OFS_LINK_DRIVE: begin
        s_d.rd_data = s_q.cfg.link_and_drive_control;
        s_d.rd_data[BIT_LINK_HS]  = i_link_high_speed;
        s_d.rd_data[BIT_DEV_KIND] = i_device_kind_flag;
      end
      OFS_DESIG_LO:   s_d.rd_data = s_q.cfg.vendor_cmd_designator_low;
      OFS_DESIG_HI:   s_d.rd_data = s_q.cfg.vendor_cmd_designator_high;
      default:        s_d.rd_data = 8'h00;
    endcase

    // Serial memory probe once, 50 ms after reset release
    s_d.probe_pulse = 1'b0;
    if (!s_q.probe_done && tick) begin
      if (s_q.probe_ms == 6'(PROBE_WAIT_MS - 1)) begin
        s_d.probe_pulse = 1'b1;
        s_d.probe_done  = 1'b1;
      end else begin
        s_d.probe_ms = s_q.probe_ms + 6'd1;
      end
    end

    // Drive initialisation sequence
    s_d.drive_reset  = 1'b0;
    s_d.devctl_wr    = 1'b0;
    s_d.set_features = 1'b0;
    expired  = tick && (limit != '0) && (s_q.init_ms + MS_W'(1) >= limit);
    want_apm = i_device_kind_flag && i_apm_supported &&
               (s_q.cfg.power_mgmt_level != 8'h00);
    case (s_q.init)
      BCR_IDLE: begin
        if (i_init_start) begin
          s_d.init        = BCR_RESET;
          s_d.init_active = 1'b1;
        end
      end
      BCR_RESET: begin
        s_d.drive_reset = 1'b1;
        s_d.init_ms     = '0;
        s_d.init        = i_skip_init ? BCR_CTL : BCR_POLL;
      end
      BCR_CTL: begin
        s_d.devctl_wr = 1'b1;
        s_d.init      = BCR_DONE;
      end
      BCR_POLL: begin
        if (i_reset_complete) begin
          s_d.init = want_apm ? BCR_APM : BCR_DONE;
        end else if (expired) begin
          s_d.init = BCR_RESET;
        end else if (tick) begin
          s_d.init_ms = s_q.init_ms + MS_W'(1);
        end
      end
      BCR_APM: begin
        s_d.set_features = 1'b1;
        s_d.init         = BCR_DONE;
      end
      BCR_DONE: begin
        s_d.init_active = 1'b0;
        s_d.init        = BCR_IDLE;
      end
      default: begin
        s_d.init        = BCR_IDLE;
        s_d.init_active = 1'b0;
      end
    endcase
  end

  // State register, ROM defaults after reset
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.cfg.event_notify_command       <= RST_EVENT_CMD;
      s_q.cfg.power_mgmt_level           <= RST_POWER_MGMT;
      s_q.cfg.drive_init_timeout         <= RST_INIT_TMO;
      s_q.cfg.link_and_drive_control     <= RST_LINK_DRIVE;
      s_q.cfg.vendor_cmd_designator_low  <= RST_DESIG_LO;
      s_q.cfg.vendor_cmd_designator_high <= RST_DESIG_HI;
      s_q.init                           <= BCR_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // Register-backed outputs
  assign o_mem_wr       = s_q.mem_wr;
  assign o_mem_addr     = s_q.mem_addr;
  assign o_mem_data     = s_q.mem_data;
  assign o_rd_data      = s_q.rd_data;
  assign o_init_active  = s_q.init_active;
  assign o_drive_reset  = s_q.drive_reset;
  assign o_devctl_wr    = s_q.devctl_wr;
  assign o_set_features = s_q.set_features;
  assign o_probe_serial = s_q.probe_pulse;
  assign o_drive_ready  = s_q.drive_ready;
  assign o_power_mgmt_level    = s_q.cfg.power_mgmt_level;

  // Control bits straight from configuration
  assign o_event_notify_cmd = s_q.cfg.event_notify_command;
  assign o_event_notify_en  = (s_q.cfg.event_notify_command != 8'h00);
  assign o_cb_len_16        = s_q.cfg.link_and_drive_control[BIT_CB_LEN_16];
  assign o_atapi_reset_en   = s_q.cfg.link_and_drive_control[BIT_ATAPI_RST];
  assign o_full_speed_lock  = s_q.cfg.link_and_drive_control[BIT_FS_LOCK];
  assign o_msc_soft_reset_sel = s_q.cfg.link_and_drive_control[BIT_MSC_RST];

  // Drive select honoured only under init bypass
  assign o_drive_select = i_skip_init &
                          s_q.cfg.link_and_drive_control[BIT_DRIVE_SEL];

  // Vendor ATA designator compare
  assign o_vendor_ata_match =
    (i_cb_designator == {s_q.cfg.vendor_cmd_designator_high,
                         s_q.cfg.vendor_cmd_designator_low});

endmodule
`default_nettype wire

//--- sim/bcr_asserts.sv
// Checker for the configuration register set ports
`default_nettype none
module bcr_asserts (
  // Clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_resetn,
  // Vendor write and memory echo
  input wire logic       i_vwr_valid,
  input wire logic [3:0] i_vwr_addr,
  input wire logic [7:0] i_vwr_data,
  input wire logic       o_mem_wr,
  input wire logic [3:0] o_mem_addr,
  input wire logic [7:0] o_mem_data,
  // Read port and live status
  input wire logic [3:0] i_rd_addr,
  input wire logic [7:0] o_rd_data,
  input wire logic       i_link_high_speed,
  input wire logic       i_device_kind_flag,
  // Drive initialisation
  input wire logic       i_apm_supported,
  input wire logic       i_skip_init,
  input wire logic       i_init_start,
  input wire logic       o_init_active,
  input wire logic       o_drive_reset,
  input wire logic       o_devctl_wr,
  input wire logic       o_set_features,
  input wire logic [7:0] o_power_mgmt_level,
  input wire logic       o_drive_select,
  // Event notification
  input wire logic [7:0] o_event_notify_cmd,
  input wire logic       o_event_notify_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // Steps of an initialisation start
  sequence s_start;
    i_init_start && !o_init_active;
  endsequence
  sequence s_kick;
    o_init_active ##1 o_drive_reset;
  endsequence

  a_vwr_echo: assert property (
    i_vwr_valid |=> o_mem_wr && o_mem_addr == $past(i_vwr_addr)
      && o_mem_data == $past(i_vwr_data))
    else $error("memory echo wrong after vendor write");
  a_mem_cause: assert property (
    o_mem_wr |-> $past(i_vwr_valid))
    else $error("memory write without vendor write");
  a_notify_en: assert property (
    o_event_notify_en == (o_event_notify_cmd != 8'h00))
    else $error("event enable does not follow command byte");
  a_drive_sel: assert property (
    !i_skip_init |-> !o_drive_select)
    else $error("drive select honoured without bypass");
  a_rd_live: assert property (
    i_rd_addr == 4'h5 |=> o_rd_data[7] == $past(i_link_high_speed)
      && o_rd_data[3] == $past(i_device_kind_flag))
    else $error("live status bits wrong in read");
  a_rd_unmapped: assert property (
    i_rd_addr < 4'h2 |=> o_rd_data == 8'h00)
    else $error("signature offset reads nonzero");
  a_sf_gate: assert property (
    o_set_features |-> o_power_mgmt_level != 8'h00 && i_apm_supported
      && i_device_kind_flag)
    else $error("set features issued when not allowed");
  a_start_kick: assert property (
    s_start |=> s_kick)
    else $error("start did not reset the drive");
  a_bypass_step: assert property (
    i_skip_init && o_drive_reset |=> o_devctl_wr)
    else $error("bypass did not write device control");
  a_pulse_one: assert property (
    o_drive_reset |=> !o_drive_reset)
    else $error("drive reset longer than one cycle");
endmodule
`default_nettype wire

//--- sim/bcr_src_model.sv
// Serial memory image model feeding the configuration load port
`default_nettype none
module bcr_src_model (
  // Clock and stream request
  input  wire logic       i_core_clk,
  input  wire logic       i_go,
  // Vendor writes passed on by the register set
  input  wire logic       i_mem_wr,
  input  wire logic [3:0] i_mem_addr,
  input  wire logic [7:0] i_mem_data,
  // Image byte stream
  output logic            o_load_valid,
  output logic [3:0]      o_load_addr,
  output logic [7:0]      o_load_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16];
  logic [4:0] pos;

  // Image starts as a ramp, stream idle
  initial begin
    for (int k = 0; k < 16; k++) mem[k] = 8'h10 + 8'(k);
    pos = 5'h10;
  end

  // Store vendor writes, step through the image
  always @(posedge i_core_clk) begin
    if (i_mem_wr) mem[i_mem_addr] <= i_mem_data;
    if (i_go) pos <= 5'h00;
    else if (!pos[4]) pos <= pos + 5'h01;
  end

  // Whole image in order, junk data when idle
  assign o_load_valid = !pos[4];
  assign o_load_addr  = pos[3:0];
  assign o_load_data  = pos[4] ? ~mem[15] : mem[pos[3:0]];
endmodule
`default_nettype wire

//--- sim/bcr_config_regs_tb.sv
// Self-checking testbench for the configuration register set
`default_nettype none
module bcr_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_core_clk = 1'b0, i_resetn = 1'b0, i_vwr_valid = 1'b0, go = 1'b0;
  logic i_link_high_speed = 1'b0, i_device_kind_flag = 1'b0;
  logic i_apm_supported = 1'b1, i_skip_init = 1'b0, i_init_start = 1'b0;
  logic i_drive_ready_in = 1'b0, i_identify_mode = 1'b0;
  logic i_reset_complete = 1'b0, i_load_valid, o_mem_wr, o_init_active;
  logic o_drive_reset, o_devctl_wr, o_set_features, o_atapi_reset_en;
  logic o_drive_select, o_probe_serial, o_full_speed_lock, o_cb_len_16;
  logic o_msc_soft_reset_sel, o_event_notify_en, o_drive_ready;
  logic o_vendor_ata_match;
  logic [3:0] i_load_addr, i_vwr_addr = 4'h0, o_mem_addr, i_rd_addr = 4'h0;
  logic [7:0] i_load_data, i_vwr_data = 8'h00, o_mem_data, o_rd_data;
  logic [7:0] o_power_mgmt_level, o_event_notify_cmd;
  logic [15:0] i_cb_designator = 16'h2424;
  int err_count = 0, checks = 0, sf_cnt = 0;

  // Clock and set-features counter
  always #20 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) if (o_set_features) sf_cnt <= sf_cnt + 1;

  bcr_config_regs #(.P_CYC_PER_MS(4)) bcr_config_regs_i (.*);
  bcr_src_model bcr_src_model_i (.i_core_clk, .i_go(go), .i_mem_wr(o_mem_wr),
    .i_mem_addr(o_mem_addr), .i_mem_data(o_mem_data),
    .o_load_valid(i_load_valid), .o_load_addr(i_load_addr),
    .o_load_data(i_load_data));

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Bounded wait for one output event
  task automatic wt(input int sel, input int n, output int c);
    for (c = 0; c < n; c++) begin
      @(posedge i_core_clk);
      #1;
      if ((sel == 0 && o_drive_reset) || (sel == 1 && o_set_features) ||
          (sel == 2 && o_devctl_wr) || (sel == 3 && o_probe_serial) ||
          (sel == 4 && !o_init_active)) return;
    end
    err_count++;
    $display("BAD t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  endtask

  // Register read one edge after the address
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_core_clk) i_rd_addr <= a;
    @(posedge i_core_clk);
    #1 chk(o_rd_data, e);
  endtask

  // Host vendor write, memory echo next cycle
  task automatic vw(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_vwr_valid <= 1'b1;
    i_vwr_addr <= a;
    i_vwr_data <= d;
    @(posedge i_core_clk) i_vwr_valid <= 1'b0;
    #1 chk({o_mem_wr, o_mem_addr, o_mem_data}, {1'b1, a, d});
  endtask

  task automatic do_reset;
    @(posedge i_core_clk) i_resetn <= 1'b0;
    repeat (10) @(posedge i_core_clk);
    i_resetn <= 1'b1;
  endtask

  task automatic t_probe;
    int c;
    wt(3, 260, c);
    chk(c > 190 && c < 215, 1'b1);
    @(posedge i_core_clk);
    #1 chk(o_probe_serial, 1'b0);
    $display("probe test done");
  endtask

  task automatic t_defaults;
    logic [7:0] e [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
                          8'h24, 8'h24, 8'h00};
    for (int k = 0; k < 9; k++) rdc(4'(k), e[k]);
    chk({o_event_notify_en, o_vendor_ata_match}, 2'b01);
    $display("defaults test done");
  endtask

  task automatic t_vendor;
    @(posedge i_core_clk);
    i_link_high_speed <= 1'b1;
    i_device_kind_flag <= 1'b1;
    vw(4'h5, 8'hFF);
    chk({o_full_speed_lock, o_cb_len_16, o_msc_soft_reset_sel,
         o_atapi_reset_en, o_drive_select}, 5'h1E);
    rdc(4'h5, 8'hFF);
    @(posedge i_core_clk) i_skip_init <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    #1 chk(o_drive_select, 1'b1);
    @(posedge i_core_clk) i_skip_init <= 1'b0;
    vw(4'h5, 8'h00);
    chk({o_full_speed_lock, o_cb_len_16, o_msc_soft_reset_sel,
         o_atapi_reset_en}, 4'h0);
    rdc(4'h5, 8'h88);
    @(posedge i_core_clk) i_link_high_speed <= 1'b0;
    rdc(4'h5, 8'h08);
    $display("vendor test done");
  endtask

  task automatic t_reload;
    logic [7:0] e [6] = '{8'hA5, 8'h13, 8'h14, 8'h00, 8'h3C, 8'h17};
    vw(4'h2, 8'hA5);
    vw(4'h6, 8'h3C);
    do_reset();
    rdc(4'h2, 8'h00);
    @(posedge i_core_clk) go <= 1'b1;
    @(posedge i_core_clk) go <= 1'b0;
    repeat (18) @(posedge i_core_clk);
    for (int k = 0; k < 6; k++)
      rdc(4'(k + 2), e[k] | ((k == 3) ? 8'h08 : 8'h00));
    chk({o_event_notify_en, o_event_notify_cmd}, 9'h1A5);
    @(posedge i_core_clk) i_cb_designator <= 16'h173C;
    #1 chk(o_vendor_ata_match, 1'b1);
    @(posedge i_core_clk) i_cb_designator <= 16'h3C17;
    #1 chk(o_vendor_ata_match, 1'b0);
    $display("reload test done");
  endtask

  // Ready pin and identify mode, then settle and compare
  task automatic pins(input logic r, input logic m, input logic e);
    @(posedge i_core_clk);
    i_drive_ready_in <= r;
    i_identify_mode <= m;
    repeat (5) @(posedge i_core_clk);
    #1 chk(o_drive_ready, e);
  endtask

  task automatic t_ready;
    vw(4'h5, 8'h01);
    pins(1'b0, 1'b0, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    pins(1'b1, 1'b1, 1'b1);
    pins(1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b1);
    vw(4'h5, 8'h00);
    $display("ready test done");
  endtask

  // One init run with reset complete at once
  task automatic run_init(input logic [7:0] pm, input logic k,
                          input logic s, input logic [3:0] e);
    int c;
    int n;
    vw(4'h3, pm);
    @(posedge i_core_clk);
    i_device_kind_flag <= k;
    i_apm_supported <= s;
    i_init_start <= 1'b1;
    @(posedge i_core_clk) i_init_start <= 1'b0;
    wt(0, 5, c);
    n = sf_cnt;
    @(posedge i_core_clk) i_reset_complete <= 1'b1;
    wt(4, 10, c);
    @(posedge i_core_clk) i_reset_complete <= 1'b0;
    chk(sf_cnt - n, e);
  endtask

  task automatic t_init;
    int c;
    run_init(8'h13, 1'b1, 1'b1, 4'h1);
    run_init(8'h00, 1'b1, 1'b1, 4'h0);
    run_init(8'h13, 1'b0, 1'b1, 4'h0);
    run_init(8'h13, 1'b1, 1'b0, 4'h0);
    vw(4'h4, 8'h01);
    @(posedge i_core_clk) i_init_start <= 1'b1;
    @(posedge i_core_clk) i_init_start <= 1'b0;
    wt(0, 5, c);
    wt(0, 600, c);
    chk(c >= 500 && c <= 530, 1'b1);
    @(posedge i_core_clk) i_reset_complete <= 1'b1;
    wt(4, 10, c);
    @(posedge i_core_clk);
    i_reset_complete <= 1'b0;
    i_skip_init <= 1'b1;
    i_init_start <= 1'b1;
    @(posedge i_core_clk) i_init_start <= 1'b0;
    wt(2, 6, c);
    chk(c, 1);
    wt(4, 6, c);
    @(posedge i_core_clk) i_skip_init <= 1'b0;
    $display("init test done");
  endtask

  initial begin
    repeat (10) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    t_probe();
    t_defaults();
    t_vendor();
    t_reload();
    t_ready();
    t_init();
    summarize();
  end
endmodule

bind bcr_config_regs bcr_asserts bcr_asserts_i (.*);
`default_nettype wire
